// *** verilog/port_function_mux.sv ***
/*
 * Port function multiplexer and general purpose I/O for 44 pins.
 * Assumes all control and peripheral signals are on clk_sys; pads are
 * asynchronous and are synchronised inside each pin cell.
 */
// Overview of operation
// - two-bit selector per pin, documented reset defaults
// - port_a pin2: SS, watchdog, analog 2
// - port_a pin3: SCK, standby, analog 3
// - port_a pin8: timer2, timer0, analog 8
// - port_a pin9: timer3, timer1, analog 9
// - port_b pin2: motor V high, SPI MOSI
// - port_b pin3: motor V low, SPI MISO
// - port_c pin11: boot default, timer0 on 10
// - port_c pin13: port, timer2, main crystal
// - port_d pin2: MOSI, I2C clock, sub crystal
// - port_d pin3: MISO, I2C data, sub crystal
// - per-pin direction input or output
// - per-pin interrupt trigger mode
// - per-pin pull-up and open-drain
// - port output follows written level
// - pad level readable per pin
`timescale 1ns/1ps
`default_nettype none
module port_function_mux (
   // clock, reset, enable
   input  wire logic                            clk_sys,
   input  wire logic                            resetn,
   input  wire logic                            ce,
   // configuration writes
   input  wire logic                            cfg_write,
   input  wire logic [2*pin_mux_pkg::NPIN-1:0]  func_data,
   input  wire logic [pin_mux_pkg::NPIN-1:0]    dir_data,
   input  wire logic [pin_mux_pkg::NPIN-1:0]    pull_data,
   input  wire logic [pin_mux_pkg::NPIN-1:0]    od_data,
   input  wire logic [2*pin_mux_pkg::NPIN-1:0]  int_data,
   input  wire logic                            out_write,
   input  wire logic [pin_mux_pkg::NPIN-1:0]    out_data,
   // peripheral drive
   input  wire logic [3:0]                      spi_out,
   input  wire logic [3:0]                      spi_oe,
   input  wire logic [3:0]                      timer_out,
   input  wire logic [3:0]                      timer_oe,
   input  wire logic [1:0]                      i2c_out,
   input  wire logic [1:0]                      i2c_oe,
   input  wire logic                            watchdog_underflow_out,
   input  wire logic                            standby_indicator_out,
   input  wire logic                            motor_phase_v_high,
   input  wire logic                            motor_phase_v_low,
   input  wire logic [pin_mux_pkg::NPIN-1:0]    alt_out,
   input  wire logic [pin_mux_pkg::NPIN-1:0]    alt_oe,
   // pads
   input  wire logic [pin_mux_pkg::NPIN-1:0]    pad_in,
   output logic      [pin_mux_pkg::NPIN-1:0]    pad_out,
   output logic      [pin_mux_pkg::NPIN-1:0]    pad_oe,
   output logic      [pin_mux_pkg::NPIN-1:0]    pad_pullup,
   // status and peripheral inputs
   output logic      [2*pin_mux_pkg::NPIN-1:0]  func_sel,
   output logic      [pin_mux_pkg::NPIN-1:0]    in_level,
   output logic      [pin_mux_pkg::NPIN-1:0]    irq_event,
   output logic      [pin_mux_pkg::NPIN-1:0]    analog_connect,
   output logic      [3:0]                      spi_in,
   output logic      [3:0]                      timer_in,
   output logic      [1:0]                      i2c_in
);
   import pin_mux_pkg::*;

   logic [NPIN-1:0]   dir;
   logic [NPIN-1:0]   pull_en;
   logic [NPIN-1:0]   open_drain;
   logic [2*NPIN-1:0] int_mode;
   logic [NPIN-1:0]   out_level;
   logic [2*NPIN-1:0] next_func_sel;
   logic [NPIN-1:0]   next_dir;
   logic [NPIN-1:0]   next_pull_en;
   logic [NPIN-1:0]   next_open_drain;
   logic [2*NPIN-1:0] next_int_mode;
   logic [NPIN-1:0]   next_out_level;
   logic [NPIN-1:0]   drv_val;
   logic [NPIN-1:0]   drv_oe;
   logic [NPIN-1:0]   none_sel;
   logic [NPIN-1:0]   gpio_sel;
   logic [NPIN-1:0]   next_analog;
   logic [3:0]        next_spi_in;
   logic [3:0]        next_timer_in;
   logic [1:0]        next_i2c_in;

   // ----------------------------------------------------------------
   // source table
   // ----------------------------------------------------------------
   function automatic src_t src_of(input int pin, input logic [1:0] fn);
      src_t s;
      s = SRC_NONE;
      if (fn == FN_PORT) s = SRC_GPIO;
      else if (fn == FN_ALT1 && FN1_MASK[pin]) s = SRC_GEN;
      else if (fn == FN_ALT2 && FN2_MASK[pin]) s = SRC_GEN;
      else if (fn == FN_ALT3 && FN3_MASK[pin]) s = SRC_ANALOG;
      case (pin)
         PIN_PA2: if (fn == FN_ALT1) s = SRC_SS; else if (fn == FN_ALT2) s = SRC_WDT;
         PIN_PA3: if (fn == FN_ALT1) s = SRC_SCK; else if (fn == FN_ALT2) s = SRC_STB;
         PIN_PA8: if (fn == FN_ALT1) s = SRC_T2; else if (fn == FN_ALT2) s = SRC_T0;
         PIN_PA9: if (fn == FN_ALT1) s = SRC_T3; else if (fn == FN_ALT2) s = SRC_T1;
         PIN_PB2: if (fn == FN_ALT1) s = SRC_MVH; else if (fn == FN_ALT2) s = SRC_MOSI;
         PIN_PB3: if (fn == FN_ALT1) s = SRC_MVL; else if (fn == FN_ALT2) s = SRC_MISO;
         PIN_PC11: if (fn == FN_ALT2) s = SRC_T0;
         PIN_PC13: if (fn == FN_ALT1) s = SRC_T2;
         PIN_PD2: if (fn == FN_ALT1) s = SRC_MOSI; else if (fn == FN_ALT2) s = SRC_SCL;
         PIN_PD3: if (fn == FN_ALT1) s = SRC_MISO; else if (fn == FN_ALT2) s = SRC_SDA;
         default: ;
      endcase
      return s;
   endfunction

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   always_comb begin
      next_func_sel   = cfg_write ? func_data : func_sel;
      next_dir        = cfg_write ? dir_data  : dir;
      next_pull_en    = cfg_write ? pull_data : pull_en;
      next_open_drain = cfg_write ? od_data   : open_drain;
      next_int_mode   = cfg_write ? int_data  : int_mode;
      next_out_level  = out_write ? out_data  : out_level;
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         func_sel   <= FUNC_RESET;
         dir        <= '0;
         pull_en    <= '0;
         open_drain <= '0;
         int_mode   <= '0;
         out_level  <= '0;
      end else if (ce) begin
         func_sel   <= next_func_sel;
         dir        <= next_dir;
         pull_en    <= next_pull_en;
         open_drain <= next_open_drain;
         int_mode   <= next_int_mode;
         out_level  <= next_out_level;
      end
   end

   // ----------------------------------------------------------------
   // routing
   // ----------------------------------------------------------------
   always_comb begin
      drv_val       = '0;
      drv_oe        = '0;
      none_sel      = '0;
      gpio_sel      = '0;
      next_analog   = '0;
      next_spi_in   = '0;
      next_timer_in = '0;
      next_i2c_in   = '0;
      for (int i = 0; i < NPIN; i++) begin
         unique case (src_of(i, func_sel[2*i +: 2]))
            SRC_NONE: none_sel[i] = 1'b1;
            SRC_GPIO: begin
               gpio_sel[i] = 1'b1;
               drv_val[i]  = out_level[i];
               drv_oe[i]   = dir[i];
            end
            SRC_GEN: begin
               drv_val[i] = alt_out[i];
               drv_oe[i]  = alt_oe[i];
            end
            SRC_ANALOG: next_analog[i] = 1'b1;
            SRC_SS, SRC_SCK, SRC_MOSI, SRC_MISO: begin
               drv_val[i] = spi_out[func_lane(src_of(i, func_sel[2*i +: 2]))];
               drv_oe[i]  = spi_oe[func_lane(src_of(i, func_sel[2*i +: 2]))];
               next_spi_in[func_lane(src_of(i, func_sel[2*i +: 2]))] =
                  next_spi_in[func_lane(src_of(i, func_sel[2*i +: 2]))] | in_level[i];
            end
            SRC_T0, SRC_T1, SRC_T2, SRC_T3: begin
               drv_val[i] = timer_out[func_lane(src_of(i, func_sel[2*i +: 2]))];
               drv_oe[i]  = timer_oe[func_lane(src_of(i, func_sel[2*i +: 2]))];
               next_timer_in[func_lane(src_of(i, func_sel[2*i +: 2]))] =
                  next_timer_in[func_lane(src_of(i, func_sel[2*i +: 2]))] | in_level[i];
            end
            SRC_WDT: begin
               drv_val[i] = watchdog_underflow_out;
               drv_oe[i]  = 1'b1;
            end
            SRC_STB: begin
               drv_val[i] = standby_indicator_out;
               drv_oe[i]  = 1'b1;
            end
            SRC_MVH: begin
               drv_val[i] = motor_phase_v_high;
               drv_oe[i]  = 1'b1;
            end
            SRC_MVL: begin
               drv_val[i] = motor_phase_v_low;
               drv_oe[i]  = 1'b1;
            end
            SRC_SCL, SRC_SDA: begin
               drv_val[i] = i2c_out[func_lane(src_of(i, func_sel[2*i +: 2]))];
               drv_oe[i]  = i2c_oe[func_lane(src_of(i, func_sel[2*i +: 2]))];
               next_i2c_in[func_lane(src_of(i, func_sel[2*i +: 2]))] =
                  next_i2c_in[func_lane(src_of(i, func_sel[2*i +: 2]))] | in_level[i];
            end
         endcase
      end
   end

   function automatic int func_lane(input src_t s);
      case (s)
         SRC_SCK, SRC_T1, SRC_SDA: return 1;
         SRC_MOSI, SRC_T2:         return 2;
         SRC_MISO, SRC_T3:         return 3;
         default:                  return 0;
      endcase
   endfunction

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         analog_connect <= '0;
         spi_in         <= '0;
         timer_in       <= '0;
         i2c_in         <= '0;
      end else if (ce) begin
         analog_connect <= next_analog;
         spi_in         <= next_spi_in;
         timer_in       <= next_timer_in;
         i2c_in         <= next_i2c_in;
      end
   end

   // ----------------------------------------------------------------
   // pin cells
   // ----------------------------------------------------------------
   // pull-up and open drain per pin; synchronised level
   for (genvar g = 0; g < NPIN; g++) begin : g_cell
      pin_cell u_cell (
         .clk_sys    (clk_sys),
         .resetn     (resetn),
         .ce         (ce),
         .drv_val    (drv_val[g]),
         .drv_oe     (drv_oe[g]),
         .open_drain (open_drain[g]),
         .pull_en    (pull_en[g]),
         .int_mode   (int_mode[2*g +: 2]),
         .pad_in     (pad_in[g]),
         .pad_out    (pad_out[g]),
         .pad_oe     (pad_oe[g]),
         .pad_pullup (pad_pullup[g]),
         .level      (in_level[g]),
         .irq        (irq_event[g])
      );
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   sequence wdt_pick;
      ce && func_sel[2*PIN_PA2 +: 2] == FN_ALT2 && !open_drain[PIN_PA2];
   endsequence
   sequence stb_pick;
      ce && func_sel[2*PIN_PA3 +: 2] == FN_ALT2 && !open_drain[PIN_PA3];
   endsequence
   sequence mvh_pick;
      ce && func_sel[2*PIN_PB2 +: 2] == FN_ALT1 && !open_drain[PIN_PB2];
   endsequence

   func_reset_a: assert property ($rose(resetn) |-> func_sel == FUNC_RESET)
      else $error("selector not at default after reset");
   wdt_route_a: assert property (wdt_pick |=> pad_oe[PIN_PA2] &&
      pad_out[PIN_PA2] == $past(watchdog_underflow_out))
      else $error("watchdog output not on port_a pin 2");
   stb_route_a: assert property (stb_pick |=> pad_oe[PIN_PA3] &&
      pad_out[PIN_PA3] == $past(standby_indicator_out))
      else $error("standby output not on port_a pin 3");
   motor_route_a: assert property (mvh_pick |=> pad_oe[PIN_PB2] &&
      pad_out[PIN_PB2] == $past(motor_phase_v_high))
      else $error("motor high output not on port_b pin 2");
   sda_in_a: assert property (ce && func_sel[2*PIN_PD3 +: 2] == FN_ALT2 |=>
      i2c_in[I2C_SDA] == $past(in_level[PIN_PD3]))
      else $error("i2c data input not taken from port_d pin 3");
   dir_input_a: assert property (ce |=> (pad_oe & $past(gpio_sel & ~dir)) == '0)
      else $error("input pin drives pad");
   edge_irq_a: assert property (ce && $past(ce) && int_mode[1:0] == INT_RISE &&
      !$past(in_level[0]) && in_level[0] |=> irq_event[0])
      else $error("rising edge interrupt missed");
   od_low_a: assert property (ce |=> (pad_out & $past(open_drain)) == '0)
      else $error("open drain pin drives high");
   out_level_a: assert property (ce |=>
      ((pad_out ^ $past(out_level)) & $past(gpio_sel & dir & ~open_drain)) == '0)
      else $error("port output differs from written level");
   in_read_a: assert property ((ce && $stable(pad_in)) [*3] |->
      in_level == $past(pad_in, 2))
      else $error("read level differs from stable pad");
   none_off_a: assert property (ce |=> (pad_oe & $past(none_sel)) == '0)
      else $error("unassigned selector drives pad");
endmodule
`default_nettype wire

// *** verilog/pin_mux_pkg.sv ***
/*
 * Constants, pin indices, function codes and default tables for the port
 * function multiplexer. Assumes pins are numbered as one flat vector:
 * port_a 0..15, port_b 16..23, port_c 24..39, port_d 40..43.
 */
`default_nettype none
package pin_mux_pkg;
   // ----------------------------------------------------------------
   // pin counts and port bases
   // ----------------------------------------------------------------
   localparam int NPIN    = 44;
   localparam int PORT_A  = 0;
   localparam int PORT_B  = 16;
   localparam int PORT_C  = 24;
   localparam int PORT_D  = 40;
   localparam int PIN_PA2  = PORT_A + 2;
   localparam int PIN_PA3  = PORT_A + 3;
   localparam int PIN_PA8  = PORT_A + 8;
   localparam int PIN_PA9  = PORT_A + 9;
   localparam int PIN_PB2  = PORT_B + 2;
   localparam int PIN_PB3  = PORT_B + 3;
   localparam int PIN_PC11 = PORT_C + 11;
   localparam int PIN_PC13 = PORT_C + 13;
   localparam int PIN_PD2  = PORT_D + 2;
   localparam int PIN_PD3  = PORT_D + 3;

   // ----------------------------------------------------------------
   // function selector codes and assignment masks
   // ----------------------------------------------------------------
   localparam logic [1:0] FN_PORT = 2'h0;
   localparam logic [1:0] FN_ALT1 = 2'h1;
   localparam logic [1:0] FN_ALT2 = 2'h2;
   localparam logic [1:0] FN_ALT3 = 2'h3;
   localparam logic [NPIN-1:0] FN1_MASK  = 44'hfffe3fff3cf;
   localparam logic [NPIN-1:0] FN2_MASK  = 44'hc08f30f030c;
   localparam logic [NPIN-1:0] FN3_MASK  = 44'hc3100000fff;
   localparam logic [NPIN-1:0] DEF1_MASK = 44'h00c03000000;

   // ----------------------------------------------------------------
   // interrupt trigger modes and peripheral lane indices
   // ----------------------------------------------------------------
   localparam logic [1:0] INT_OFF  = 2'h0;
   localparam logic [1:0] INT_RISE = 2'h1;
   localparam logic [1:0] INT_FALL = 2'h2;
   localparam logic [1:0] INT_BOTH = 2'h3;
   localparam int SPI_SS   = 0;
   localparam int SPI_SCK  = 1;
   localparam int SPI_MOSI = 2;
   localparam int SPI_MISO = 3;
   localparam int I2C_SCL  = 0;
   localparam int I2C_SDA  = 1;

   typedef enum logic [4:0] {
      SRC_NONE, SRC_GPIO, SRC_GEN, SRC_ANALOG,
      SRC_SS, SRC_SCK, SRC_MOSI, SRC_MISO,
      SRC_T0, SRC_T1, SRC_T2, SRC_T3,
      SRC_WDT, SRC_STB, SRC_MVH, SRC_MVL, SRC_SCL, SRC_SDA
   } src_t;

   function automatic logic [2*NPIN-1:0] func_reset();
      logic [2*NPIN-1:0] r;
      r = '0;
      for (int i = 0; i < NPIN; i++) begin
         r[2*i +: 2] = DEF1_MASK[i] ? FN_ALT1 : FN_PORT;
      end
      return r;
   endfunction

   localparam logic [2*NPIN-1:0] FUNC_RESET = func_reset();
endpackage
`default_nettype wire

// *** verilog/pin_cell.sv ***
/*
 * One pad cell: input synchroniser, registered pad drive with open-drain
 * and pull-up handling, and edge interrupt detection.
 * Assumes drive requests come from logic on clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none
module pin_cell (
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       resetn,
   input  wire logic       ce,
   // drive request
   input  wire logic       drv_val,
   input  wire logic       drv_oe,
   input  wire logic       open_drain,
   input  wire logic       pull_en,
   input  wire logic [1:0] int_mode,
   // pad
   input  wire logic       pad_in,
   output logic            pad_out,
   output logic            pad_oe,
   output logic            pad_pullup,
   // input side
   output logic            level,
   output logic            irq
);
   import pin_mux_pkg::*;

   logic sync1;
   logic prev;
   logic next_out;
   logic next_oe;
   logic next_pull;
   logic next_irq;

   // ----------------------------------------------------------------
   // next values
   // ----------------------------------------------------------------
   always_comb begin
      if (open_drain) begin
         next_out = 1'b0;
         next_oe  = drv_oe & ~drv_val;
      end else begin
         next_out = drv_val;
         next_oe  = drv_oe;
      end
      next_pull = pull_en & ~next_oe;
      unique case (int_mode)
         INT_OFF:  next_irq = 1'b0;
         INT_RISE: next_irq = level & ~prev;
         INT_FALL: next_irq = ~level & prev;
         INT_BOTH: next_irq = level ^ prev;
      endcase
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         sync1      <= 1'b0;
         level      <= 1'b0;
         prev       <= 1'b0;
         pad_out    <= 1'b0;
         pad_oe     <= 1'b0;
         pad_pullup <= 1'b0;
         irq        <= 1'b0;
      end else if (ce) begin
         sync1      <= pad_in;
         level      <= sync1;
         prev       <= level;
         pad_out    <= next_out;
         pad_oe     <= next_oe;
         pad_pullup <= next_pull;
         irq        <= next_irq;
      end
   end
endmodule
`default_nettype wire

// *** verification/board_pads.sv ***
/*
 * board side of the 44 pads: resolves each pad from device drive, an
 * external driver and the pull-up.
 * assumes pad vectors come from port_function_mux on clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none
module board_pads (
   // clock
   input  wire logic                         clk_sys,
   // device side
   input  wire logic [pin_mux_pkg::NPIN-1:0] pad_out,
   input  wire logic [pin_mux_pkg::NPIN-1:0] pad_oe,
   input  wire logic [pin_mux_pkg::NPIN-1:0] pad_pullup,
   // external drivers
   input  wire logic [pin_mux_pkg::NPIN-1:0] ext_val,
   input  wire logic [pin_mux_pkg::NPIN-1:0] ext_en,
   // resolved levels
   output logic      [pin_mux_pkg::NPIN-1:0] pad_in
);
   import pin_mux_pkg::*;
   // floating pads change every cycle
   logic [NPIN-1:0] float_pat = '0;
   always @(posedge clk_sys) begin
      float_pat <= ~float_pat;
   end
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
                 | (~pad_oe & ~ext_en & (pad_pullup | float_pat));
endmodule
`default_nettype wire

// *** verification/tb_port_function_mux.sv ***
/*
 * self-checking bench for port_function_mux with a board pad model.
 * assumes the pin numbering and codes of pin_mux_pkg.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_port_function_mux;
   import pin_mux_pkg::*;
   logic                 clk_sys, resetn, ce, cfg_write, out_write;
   logic [2*NPIN-1:0]    func_data, int_data, func_sel, fsel;
   logic [NPIN-1:0]      dir_data, pull_data, od_data, out_data, alt_out, alt_oe;
   logic [NPIN-1:0]      pad_in, pad_out, pad_oe, pad_pullup, in_level;
   logic [NPIN-1:0]      irq_event, analog_connect, ext_val, ext_en;
   logic [3:0]           spi_out, spi_oe, timer_out, timer_oe, spi_in, timer_in;
   logic [1:0]           i2c_out, i2c_oe, i2c_in;
   logic                 watchdog_underflow_out, standby_indicator_out;
   logic                 motor_phase_v_high, motor_phase_v_low;
   int                   mismatches, n_checks, cyc, n, p;
   int                   irq_exp [4] = '{0, 1, 1, 2};
   int                   tbl [24][3] = '{
      '{PIN_PA2, 1, SRC_SS}, '{PIN_PA2, 2, SRC_WDT}, '{PIN_PA2, 3, SRC_ANALOG},
      '{PIN_PA3, 1, SRC_SCK}, '{PIN_PA3, 2, SRC_STB}, '{PIN_PA3, 3, SRC_ANALOG},
      '{PIN_PA8, 1, SRC_T2}, '{PIN_PA8, 2, SRC_T0}, '{PIN_PA8, 3, SRC_ANALOG},
      '{PIN_PA9, 1, SRC_T3}, '{PIN_PA9, 2, SRC_T1}, '{PIN_PA9, 3, SRC_ANALOG},
      '{PIN_PB2, 1, SRC_MVH}, '{PIN_PB2, 2, SRC_MOSI}, '{PIN_PB3, 1, SRC_MVL},
      '{PIN_PB3, 2, SRC_MISO}, '{PIN_PC11, 2, SRC_T0}, '{PIN_PC13, 1, SRC_T2},
      '{PIN_PC13, 3, SRC_ANALOG}, '{PIN_PD2, 1, SRC_MOSI}, '{PIN_PD2, 2, SRC_SCL},
      '{PIN_PD3, 1, SRC_MISO}, '{PIN_PD3, 2, SRC_SDA}, '{PIN_PD3, 3, SRC_ANALOG}};

   port_function_mux dut_u (.clk_sys, .resetn, .ce, .cfg_write, .func_data, .dir_data,
      .pull_data, .od_data, .int_data, .out_write, .out_data, .spi_out, .spi_oe,
      .timer_out, .timer_oe, .i2c_out, .i2c_oe, .watchdog_underflow_out,
      .standby_indicator_out, .motor_phase_v_high, .motor_phase_v_low, .alt_out,
      .alt_oe, .pad_in, .pad_out, .pad_oe, .pad_pullup, .func_sel, .in_level,
      .irq_event, .analog_connect, .spi_in, .timer_in, .i2c_in);
   board_pads board_u (.clk_sys, .pad_out, .pad_oe, .pad_pullup, .ext_val, .ext_en,
      .pad_in);

   // ----------------------------------------------------------------
   // clock, timeout and shared tasks
   // ----------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 4000) begin
         mismatches++;
         wrap_up();
      end
   end
   task automatic step(input int k);
      repeat (k) @(posedge clk_sys);
      #2;
   endtask
   task automatic check(input logic [2*NPIN-1:0] seen, input logic [2*NPIN-1:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cfg(input logic [2*NPIN-1:0] f, input logic [NPIN-1:0] d,
                      input logic [NPIN-1:0] pu, input logic [NPIN-1:0] od,
                      input logic [2*NPIN-1:0] im);
      func_data = f; dir_data = d; pull_data = pu; od_data = od; int_data = im;
      cfg_write = 1'b1;
      step(1);
      cfg_write = 1'b0;
   endtask
   task automatic wr_out(input logic [NPIN-1:0] v);
      out_data = v;
      out_write = 1'b1;
      step(1);
      out_write = 1'b0;
   endtask
   task automatic periph(input logic v);
      {spi_out, timer_out, i2c_out} = '0;
      {watchdog_underflow_out, standby_indicator_out} = '0;
      {motor_phase_v_high, motor_phase_v_low} = {v, v};
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      {resetn, cfg_write, out_write, func_data, int_data, dir_data} = '0;
      {pull_data, od_data, out_data, alt_out, alt_oe, ext_val, ext_en} = '0;
      {spi_out, timer_out, i2c_out} = '0;
      {spi_oe, timer_oe, i2c_oe} = '1;
      periph(1'b0);
      ce = 1'b1;
      step(4);
      resetn = 1'b1;
      step(1);
      fsel = '0;
      foreach (fsel[i]) if (i inside {49, 51, 69, 71}) fsel[i - 1] = 1'b1;
      check(func_sel, fsel);
      check(pad_oe, '0);
      // direction, output level and input read
      ext_val = 44'h123456789ab;
      ext_en = '1;
      cfg('0, 44'haaaaaaaaaaa, '0, '0, '0);
      wr_out(44'hf0f0f0f0f0f);
      step(3);
      check(pad_oe, 44'haaaaaaaaaaa);
      check(pad_out & 44'haaaaaaaaaaa, 44'ha0a0a0a0a0a);
      check(in_level, 44'ha0a0a0a0a0a | (44'h123456789ab & 44'h55555555555));
      // open drain with pull-up on pin 5
      ext_en = 44'h1;
      cfg('0, 44'h20, 44'h20, 44'h20, '0);
      wr_out(44'h20);
      step(3);
      check({pad_oe[5], pad_pullup[5], in_level[5]}, 3'b011);
      wr_out('0);
      step(3);
      check({pad_oe[5], pad_out[5], pad_pullup[5]}, 3'b100);
      // edge trigger modes on pin 0
      for (int m = 0; m < 4; m++) begin
         cfg('0, '0, '0, '0, 88'(m));
         ext_val[0] = 1'b0;
         step(4);
         n = 0;
         ext_val[0] = 1'b1;
         repeat (6) begin step(1); if (irq_event[0] === 1'b1) n++; end
         ext_val[0] = 1'b0;
         repeat (6) begin step(1); if (irq_event[0] === 1'b1) n++; end
         check(88'(n), 88'(irq_exp[m]));
      end
      // alternative function routing
      ext_en = '0;
      for (int i = 0; i < 24; i++) begin
         p = tbl[i][0];
         {spi_out, timer_out, i2c_out} = '0;
         {watchdog_underflow_out, standby_indicator_out} = '0;
         {motor_phase_v_high, motor_phase_v_low} = '0;
         case (src_t'(tbl[i][2]))
            SRC_SS:   spi_out[SPI_SS] = 1'b1;
            SRC_SCK:  spi_out[SPI_SCK] = 1'b1;
            SRC_MOSI: spi_out[SPI_MOSI] = 1'b1;
            SRC_MISO: spi_out[SPI_MISO] = 1'b1;
            SRC_T0:   timer_out[0] = 1'b1;
            SRC_T1:   timer_out[1] = 1'b1;
            SRC_T2:   timer_out[2] = 1'b1;
            SRC_T3:   timer_out[3] = 1'b1;
            SRC_SCL:  i2c_out[I2C_SCL] = 1'b1;
            SRC_SDA:  i2c_out[I2C_SDA] = 1'b1;
            SRC_WDT:  watchdog_underflow_out = 1'b1;
            SRC_STB:  standby_indicator_out = 1'b1;
            SRC_MVH:  motor_phase_v_high = 1'b1;
            SRC_MVL:  motor_phase_v_low = 1'b1;
            default:  ;
         endcase
         fsel = '0;
         fsel[2*p +: 2] = 2'(tbl[i][1]);
         cfg(fsel, '0, '0, '0, '0);
         step(3);
         if (tbl[i][2] == SRC_ANALOG) check({analog_connect[p], pad_oe[p]}, 2'b10);
         else check({pad_out[p], pad_oe[p], in_level[p]}, 3'b111);
         step(1);
         check({spi_in, timer_in, i2c_in}, {spi_out, timer_out, i2c_out});
      end
      // unassigned codes leave the pad undriven
      {spi_out, timer_out, i2c_out, alt_out, alt_oe} = '1;
      {watchdog_underflow_out, standby_indicator_out} = '1;
      {motor_phase_v_high, motor_phase_v_low} = '1;
      fsel = '0;
      fsel[2*(PORT_A + 4) +: 2] = FN_ALT1;
      fsel[2*PIN_PB2 +: 2] = FN_ALT3;
      fsel[2*(PORT_B + 6) +: 2] = FN_ALT2;
      cfg(fsel, '0, '0, '0, '0);
      step(3);
      check({pad_oe[PORT_A + 4], pad_oe[PIN_PB2], pad_oe[PORT_B + 6]}, 3'b000);
      // clock enable low freezes the selector
      ce = 1'b0;
      cfg('0, '0, '0, '0, '0);
      step(2);
      check(func_sel, fsel);
      ce = 1'b1;
      step(1);
      wrap_up();
   end
endmodule
`default_nettype wire
